/* ir_timer_pkg.sv */
// Shared constants for the infrared carrier and modulation timer.
// Assumes an APB slave with 32-bit data and byte addresses.
package ir_timer_pkg;

    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int COUNT_W = 16;
    localparam int BYTE_W  = 8;
    localparam int FLAG_W  = 3;
    localparam int PRESC_W = 3;
    localparam int CTRL_W  = 10;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CARRIER  = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_INTERVAL = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_COUNT    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_CAPTURE  = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_MASK     = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_POWER    = 8'h1C;

    // Control register fields
    localparam int CTRL_RUN     = 0;
    localparam int CTRL_DIR     = 1;
    localparam int CTRL_DATA    = 2;
    localparam int CTRL_POL     = 3;
    localparam int CTRL_RESTART = 4;
    localparam int CTRL_EDGE_LO = 5;
    localparam int CTRL_FINE    = 7;
    localparam int CTRL_DIV_LO  = 8;

    // Status and mask fields
    localparam int FLAG_WRAP     = 0;
    localparam int FLAG_INTERVAL = 1;
    localparam int FLAG_CAPTURE  = 2;

    // Power control fields
    localparam int PWR_LEVEL = 0;
    localparam int PWR_DRIVE = 1;
    localparam int PWR_PIN   = 2;

    localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_TOP  = 16'hFFFF;

    typedef enum logic [1:0] {
        RUN_IDLE,
        TX_RUN,
        RX_RUN
    } run_e;

endpackage

/* carrier_generator.sv */
// Carrier waveform generator: high for highTime+1 ticks, low for lowTime+1.
// Assumes tick is a one-cycle enable from the input clock divider.
`timescale 1ns/10ps
`default_nettype none
module carrier_generator
    import ir_timer_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              run,
    input  wire logic              tick,
    input  wire logic [BYTE_W-1:0] highTime,
    input  wire logic [BYTE_W-1:0] lowTime,
    output logic                   carrierLevel,
    output logic                   carrierEdge
);
    typedef struct packed {
        logic              level;
        logic              edgeP;
        logic [BYTE_W-1:0] cnt;
    } gen_s;

    gen_s st_r;
    gen_s st_nxt;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.edgeP = 1'b0;
        if (!run) begin
            st_nxt.level = 1'b1;
            st_nxt.cnt   = '0;
        end else if (tick) begin
            if (st_r.cnt == (st_r.level ? highTime : lowTime)) begin
                st_nxt.cnt   = '0;
                st_nxt.level = !st_r.level;
                // One full carrier period ends on the rise back to high
                st_nxt.edgeP = !st_r.level;
            end else begin
                st_nxt.cnt = st_r.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign carrierLevel = st_r.level;
    assign carrierEdge  = st_r.edgeP;
endmodule
`default_nettype wire

/* capture_edge_detect.sv */
// Edge qualifier for the receive pin; edgeSelect 01 rise, 10 fall, 11 both.
// Assumes rxLevel is already synchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none
module capture_edge_detect (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       armed,
    input  wire logic       rxLevel,
    input  wire logic [1:0] edgeSelect,
    output logic            capturePulse
);
    typedef struct packed {
        logic prev;
        logic pulse;
    } edge_s;

    edge_s st_r;
    edge_s st_nxt;

    always_comb begin
        st_nxt.prev  = rxLevel;
        st_nxt.pulse = armed && ((edgeSelect[0] && rxLevel && !st_r.prev)
                              || (edgeSelect[1] && !rxLevel && st_r.prev));
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign capturePulse = st_r.pulse;
endmodule
`default_nettype wire

/* ir_carrier_timer.sv */
// Infrared carrier generation and modulation timer with APB registers.
// Assumes an APB master on clk_sys and a receive pin synchronous to it.
`timescale 1ns/10ps
`default_nettype none
module ir_carrier_timer
    import ir_timer_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0]      prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              receivePinLevel,
    input  wire logic              sendPinIn,
    output logic                   sendPinOut,
    output logic                   sendPinOe,
    output logic                   irq
);
    typedef struct packed {
        run_e               state;
        logic [CTRL_W-1:0]  ctrl;
        logic [COUNT_W-1:0] shape;
        logic [COUNT_W-1:0] shapeLat;
        logic [COUNT_W-1:0] modInt;
        logic [COUNT_W-1:0] count;
        logic [COUNT_W-1:0] capture;
        logic               dataLat;
        logic               polLat;
        logic [FLAG_W-1:0]  status;
        logic [FLAG_W-1:0]  mask;
        logic               forceLevel;
        logic               forceDrive;
        logic [PRESC_W-1:0] presc;
        logic               pinOut;
        logic               pinOe;
        logic               irq;
        logic               pready;
        logic               pslverr;
        logic [DATA_W-1:0]  prdata;
    } core_s;

    core_s st_r;
    core_s st_nxt;

    logic tick;
    logic carrierLevel;
    logic carrierEdge;
    logic countClk;
    logic capturePulse;
    logic wrAcc;
    logic rdSetup;
    logic pinLevel;

    function automatic logic regHit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] off);
        regHit = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction

    function automatic logic [PRESC_W-1:0] divMask(input logic [1:0] div);
        case (div)
            2'h0:    divMask = 3'h0;
            2'h1:    divMask = 3'h1;
            2'h2:    divMask = 3'h3;
            default: divMask = 3'h7;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Carrier path

    assign tick = (st_r.presc & divMask(st_r.ctrl[CTRL_DIV_LO +: 2]))
                  == divMask(st_r.ctrl[CTRL_DIV_LO +: 2]);
    // Fine mode counts divided input clock ticks instead of whole carrier periods
    assign countClk = st_r.ctrl[CTRL_FINE] ? tick : carrierEdge;
    assign pinLevel = st_r.dataLat ? (carrierLevel ^ st_r.polLat)
                                   : st_r.polLat;

    carrier_generator u_carrier (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .run          (st_r.state != RUN_IDLE),
        .tick         (tick),
        .highTime     (st_r.shapeLat[COUNT_W-1:BYTE_W]),
        .lowTime      (st_r.shapeLat[BYTE_W-1:0]),
        .carrierLevel (carrierLevel),
        .carrierEdge  (carrierEdge)
    );

    capture_edge_detect u_capture (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .armed        (st_r.state == RX_RUN),
        .rxLevel      (receivePinLevel),
        .edgeSelect   (st_r.ctrl[CTRL_EDGE_LO +: 2]),
        .capturePulse (capturePulse)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus strobes: one wait-free access phase, pready registered

    assign wrAcc   = psel && penable && pwrite && st_r.pready;
    assign rdSetup = psel && !penable;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [FLAG_W-1:0] setEv;
        logic [FLAG_W-1:0] clrEv;
        logic [DATA_W-1:0] rdVal;
        logic              mapped;
        setEv  = '0;
        clrEv  = '0;
        rdVal  = '0;
        mapped = 1'b1;
        st_nxt = st_r;
        st_nxt.presc = st_r.presc + 3'h1;

        case (st_r.state)
            RUN_IDLE: begin
                if (st_r.ctrl[CTRL_RUN]) begin
                    st_nxt.shapeLat = st_r.shape;
                    if (st_r.ctrl[CTRL_DIR]) begin
                        st_nxt.state   = TX_RUN;
                        st_nxt.count   = st_r.modInt;
                        st_nxt.dataLat = st_r.ctrl[CTRL_DATA];
                        st_nxt.polLat  = st_r.ctrl[CTRL_POL];
                    end else begin
                        st_nxt.state = RX_RUN;
                    end
                end
            end
            TX_RUN: begin
                // Leaving through idle restarts the carrier cleanly
                if (!st_r.ctrl[CTRL_RUN] || !st_r.ctrl[CTRL_DIR]) begin
                    st_nxt.state = RUN_IDLE;
                end else if (countClk) begin
                    if (st_r.count == COUNT_ZERO) begin
                        st_nxt.count    = st_r.modInt;
                        st_nxt.shapeLat = st_r.shape;
                        st_nxt.dataLat  = st_r.ctrl[CTRL_DATA];
                        st_nxt.polLat   = st_r.ctrl[CTRL_POL];
                        setEv[FLAG_INTERVAL] = 1'b1;
                    end else begin
                        st_nxt.count = st_r.count - 16'h0001;
                    end
                end
            end
            RX_RUN: begin
                if (!st_r.ctrl[CTRL_RUN] || st_r.ctrl[CTRL_DIR]) begin
                    st_nxt.state = RUN_IDLE;
                end else begin
                    st_nxt.shapeLat = st_r.shape;
                    if (capturePulse) begin
                        st_nxt.capture       = st_r.count;
                        setEv[FLAG_CAPTURE] = 1'b1;
                    end
                    if (capturePulse && st_r.ctrl[CTRL_RESTART]) begin
                        st_nxt.count = COUNT_ZERO;
                    end else if (countClk) begin
                        if (st_r.count == COUNT_TOP) begin
                            setEv[FLAG_WRAP] = 1'b1;
                        end
                        st_nxt.count = st_r.count + 16'h0001;
                    end
                end
            end
            default: begin
                st_nxt.state = RUN_IDLE;
            end
        endcase

        // Software writes; a count write overrides the hardware step
        if (wrAcc) begin
            if (regHit(paddr, OFF_CTRL)) begin
                st_nxt.ctrl = pwdata[CTRL_W-1:0];
            end
            if (regHit(paddr, OFF_CARRIER)) begin
                st_nxt.shape = pwdata[COUNT_W-1:0];
            end
            if (regHit(paddr, OFF_INTERVAL)) begin
                st_nxt.modInt = pwdata[COUNT_W-1:0];
            end
            if (regHit(paddr, OFF_COUNT)) begin
                st_nxt.count = pwdata[COUNT_W-1:0];
            end
            if (regHit(paddr, OFF_STATUS)) begin
                clrEv = pwdata[FLAG_W-1:0];
            end
            if (regHit(paddr, OFF_MASK)) begin
                st_nxt.mask = pwdata[FLAG_W-1:0];
            end
            if (regHit(paddr, OFF_POWER)) begin
                st_nxt.forceLevel = pwdata[PWR_LEVEL];
                st_nxt.forceDrive = pwdata[PWR_DRIVE];
            end
        end

        // A new event in the clearing cycle is kept
        st_nxt.status = (st_r.status & ~clrEv) | setEv;
        st_nxt.irq    = |(st_nxt.status & st_nxt.mask);

        // Pin owned by the timer when enabled, else by the override bits
        if (st_r.ctrl[CTRL_RUN]) begin
            st_nxt.pinOe  = 1'b1;
            st_nxt.pinOut = (st_r.state == TX_RUN) ? pinLevel
                                                   : st_r.ctrl[CTRL_POL];
        end else begin
            st_nxt.pinOe  = st_r.forceDrive;
            st_nxt.pinOut = st_r.forceLevel;
        end

        // Read data is sampled in the setup cycle
        case (paddr[ADDR_W-1:2])
            OFF_CTRL[ADDR_W-1:2]:     rdVal[CTRL_W-1:0]  = st_r.ctrl;
            OFF_CARRIER[ADDR_W-1:2]:  rdVal[COUNT_W-1:0] = st_r.shape;
            OFF_INTERVAL[ADDR_W-1:2]: rdVal[COUNT_W-1:0] = st_r.modInt;
            OFF_COUNT[ADDR_W-1:2]:    rdVal[COUNT_W-1:0] = st_r.count;
            OFF_CAPTURE[ADDR_W-1:2]:  rdVal[COUNT_W-1:0] = st_r.capture;
            OFF_STATUS[ADDR_W-1:2]:   rdVal[FLAG_W-1:0]  = st_r.status;
            OFF_MASK[ADDR_W-1:2]:     rdVal[FLAG_W-1:0]  = st_r.mask;
            OFF_POWER[ADDR_W-1:2]: begin
                rdVal[PWR_LEVEL] = st_r.forceLevel;
                rdVal[PWR_DRIVE] = st_r.forceDrive;
                rdVal[PWR_PIN]   = sendPinIn;
            end
            default: mapped = 1'b0;
        endcase
        st_nxt.pready  = rdSetup;
        st_nxt.pslverr = rdSetup && !mapped;
        if (rdSetup) begin
            st_nxt.prdata = rdVal;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; reset leaves the send pin undriven

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata     = st_r.prdata;
    assign pready     = st_r.pready;
    assign pslverr    = st_r.pslverr;
    assign sendPinOut = st_r.pinOut;
    assign sendPinOe  = st_r.pinOe;
    assign irq        = st_r.irq;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_wrap_irq_gate: assert property (
        $rose(st_r.status[FLAG_WRAP]) |-> (irq == (st_r.mask[FLAG_WRAP]
            || |(st_r.status[FLAG_W-1:1] & st_r.mask[FLAG_W-1:1]))))
        else $error("wrap interrupt not gated by its enable");

    a_wrap_flag_set: assert property (
        st_r.state == RX_RUN && st_r.ctrl[CTRL_RUN] && !st_r.ctrl[CTRL_DIR]
        && countClk && !capturePulse && !wrAcc && st_r.count == COUNT_TOP
        |=> st_r.status[FLAG_WRAP] && st_r.count == COUNT_ZERO)
        else $error("wrap did not set flag");

    a_flag_sticky: assert property (
        st_r.status[FLAG_WRAP]
        && !(wrAcc && regHit(paddr, OFF_STATUS) && pwdata[FLAG_WRAP])
        |=> st_r.status[FLAG_WRAP])
        else $error("wrap flag dropped without clear");

    a_tx_reload: assert property (
        st_r.state == TX_RUN && st_r.ctrl[CTRL_RUN] && st_r.ctrl[CTRL_DIR]
        && countClk && !wrAcc && st_r.count == COUNT_ZERO
        |=> st_r.count == $past(st_r.modInt)
            && st_r.status[FLAG_INTERVAL])
        else $error("interval end did not reload");

    a_tx_count_down: assert property (
        st_r.state == TX_RUN && st_r.ctrl[CTRL_RUN] && st_r.ctrl[CTRL_DIR]
        && countClk && !wrAcc && st_r.count != COUNT_ZERO
        |=> st_r.count == $past(st_r.count) - 16'h0001)
        else $error("transmit count did not decrement");

    a_rx_count_up: assert property (
        st_r.state == RX_RUN && st_r.ctrl[CTRL_RUN] && !st_r.ctrl[CTRL_DIR]
        && countClk && !capturePulse && !wrAcc
        |=> st_r.count == $past(st_r.count) + 16'h0001)
        else $error("receive count did not increment");

    a_rx_restart: assert property (
        st_r.state == RX_RUN && st_r.ctrl[CTRL_RUN] && !st_r.ctrl[CTRL_DIR]
        && capturePulse && st_r.ctrl[CTRL_RESTART] && !wrAcc
        |=> st_r.count == COUNT_ZERO
            && st_r.capture == $past(st_r.count))
        else $error("capture did not restart count");

    a_force_pin: assert property (
        !st_r.ctrl[CTRL_RUN] |=> sendPinOe == $past(st_r.forceDrive)
                                 && sendPinOut == $past(st_r.forceLevel))
        else $error("override bits not on send pin");

    a_timer_owns_pin: assert property (
        st_r.ctrl[CTRL_RUN] |=> sendPinOe)
        else $error("enabled timer does not drive send pin");

    a_idle_level: assert property (
        st_r.state == TX_RUN && st_r.ctrl[CTRL_RUN] && !st_r.dataLat
        |=> sendPinOut == $past(st_r.polLat))
        else $error("send pin not at idle level");

    a_irq_level: assert property (
        st_r.status[FLAG_WRAP] && st_r.mask[FLAG_WRAP] |-> irq)
        else $error("interrupt low with enabled wrap flag set");

    a_capture_flag: assert property (
        st_r.state == RX_RUN && st_r.ctrl[CTRL_RUN] && !st_r.ctrl[CTRL_DIR]
        && capturePulse
        |=> st_r.status[FLAG_CAPTURE] && st_r.capture == $past(st_r.count))
        else $error("capture did not store count or set flag");
endmodule
`default_nettype wire

/* ir_far_side.sv */
// Far side model: emitter load on the send pin, receiver front end.
// Assumes the bench steers rxWanted; the send pin has no pullup.
`timescale 1ns/10ps
`default_nettype none
module ir_far_side (
    input  wire logic clk_sys,
    input  wire logic sendPinOut,
    input  wire logic sendPinOe,
    input  wire logic rxWanted,
    output logic      sendPinIn,
    output logic      receivePinLevel
);
    logic floatBit = 1'b0;

    // Floating pin: toggle so a stale level never reads as a match
    always @(posedge clk_sys) begin
        floatBit <= ~floatBit;
    end

    assign sendPinIn = sendPinOe ? sendPinOut : floatBit;

    ////////////////////////////////////////////////////////////////////////
    // Receiver output is synchronous to clk_sys, as the block expects
    always @(posedge clk_sys) begin
        receivePinLevel <= rxWanted;
    end
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the infrared carrier and modulation timer.
// Assumes the APB timing and register map of the timer package.
`timescale 1ns/10ps
`default_nettype none
module testbench
    import ir_timer_pkg::*;
;
    logic              clk_sys, rst, psel, penable, pwrite, rxWanted;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd, c1;
    logic              pready, pslverr, er, p;
    logic              receivePinLevel, sendPinIn, sendPinOut, sendPinOe;
    logic              irq;
    int                n_fail, checks, seed, h, l, n, hi, lo, dv;

    ir_carrier_timer dut_u (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .receivePinLevel(receivePinLevel), .sendPinIn(sendPinIn),
        .sendPinOut(sendPinOut), .sendPinOe(sendPinOe), .irq(irq)
    );

    ir_far_side far_u (
        .clk_sys(clk_sys), .sendPinOut(sendPinOut), .sendPinOe(sendPinOe),
        .rxWanted(rxWanted), .sendPinIn(sendPinIn),
        .receivePinLevel(receivePinLevel)
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////
    task test_done;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask

    task chk_range(input logic [31:0] got, input logic [31:0] lo_v,
                   input logic [31:0] hi_v, input string s);
        checks++;
        if (!(got >= lo_v && got <= hi_v)) begin
            n_fail++;
            $display("[ERR] %0t %s got %h", $time, s, got);
        end
    endtask

    // One transfer; the request is held until pready is sampled high
    task apb(input logic w, input logic [ADDR_W-1:0] a,
             input logic [DATA_W-1:0] d);
        int k;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t no pready", $time);
            test_done;
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        apb(1'b1, a, d);
    endtask

    task rdr(input logic [ADDR_W-1:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task wt(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask

    // Cycles the send pin stays at lvl, bounded
    task runlen(input logic lvl, output int c);
        c = 0;
        while (sendPinOut === lvl && c < 600) begin
            @(posedge clk_sys);
            #1;
            c++;
        end
        if (c >= 600) begin
            n_fail++;
            $display("[ERR] %0t send pin stuck", $time);
            test_done;
        end
    endtask

    function automatic logic [31:0] bitv(input int pos);
        bitv = 32'h0000_0001 << pos;
    endfunction

    function automatic int expHigh(input int hh, input int ll, input logic pp);
        expHigh = pp ? ll + 1 : hh + 1;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h6ad611ae;
        rst = 1'b1;
        {psel, penable, pwrite, rxWanted} = 4'h0;
        paddr = '0;
        pwdata = '0;
        n_fail = 0;
        checks = 0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk({29'h0, sendPinOe, irq, pready}, 32'h0, "reset pins");
        for (int i = 0; i < 7; i++) begin
            rdr(8'(i * 4));
            chk(rd, 32'h0, "reset value");
        end
        rdr(OFF_POWER);
        chk(rd & 32'h3, 32'h0, "power reset");
        rdr(8'h20);
        chk({rd[30:0], er}, 32'h1, "unmapped read");
        wr(8'h24, 32'hFFFF_FFFF);
        wt(1);
        chk({31'h0, er}, 32'h1, "unmapped write");
        chk({31'h0, sendPinOe}, 32'h0, "pin after stray write");
        $display("test registers done");

        wr(OFF_POWER, 32'h3);
        wt(1);
        chk({30'h0, sendPinOe, sendPinOut}, 32'h3, "force high");
        rdr(OFF_POWER);
        chk(rd, 32'h7, "power readback");
        wr(OFF_POWER, 32'h2);
        wt(1);
        chk({30'h0, sendPinOe, sendPinOut}, 32'h2, "force low");
        wr(OFF_CTRL, bitv(CTRL_RUN) | bitv(CTRL_POL));
        wt(2);
        chk({30'h0, sendPinOe, sendPinOut}, 32'h3, "force ignored");
        wr(OFF_CTRL, 32'h0);
        wr(OFF_POWER, 32'h0);
        wt(2);
        chk({31'h0, sendPinOe}, 32'h0, "release pin");
        $display("test override done");

        // Corner shapes first, then random ones
        for (int t = 0; t < 4; t++) begin
            h = (t == 0) ? 0 : (t == 1) ? 255 : $random(seed) & 7;
            l = (t < 2) ? 0 : $random(seed) & 7;
            p = $random(seed);
            // Last shape also runs the input clock divider
            dv = (t == 3) ? 1 + ($random(seed) & 1) : 0;
            wr(OFF_CARRIER, {16'h0, 8'(h), 8'(l)});
            rdr(OFF_CARRIER);
            chk(rd, {16'h0, 8'(h), 8'(l)}, "carrier rw");
            wr(OFF_INTERVAL, 32'h0000_0020);
            wr(OFF_CTRL, bitv(CTRL_RUN) | bitv(CTRL_DIR) | bitv(CTRL_DATA)
                         | (p ? bitv(CTRL_POL) : 32'h0)
                         | 32'(dv << CTRL_DIV_LO));
            wt(1);
            // Skip the idle level and the first, partial, period
            runlen(1'b1, n);
            runlen(1'b0, n);
            runlen(1'b1, n);
            runlen(1'b0, n);
            runlen(1'b1, hi);
            runlen(1'b0, lo);
            chk(hi, expHigh(h, l, p) << dv, "carrier high");
            chk(lo, expHigh(l, h, p) << dv, "carrier low");
            chk({31'h0, sendPinOe}, 32'h1, "tx drive");
            wr(OFF_CTRL, 32'h0);
        end
        $display("test carrier done");

        wr(OFF_STATUS, 32'h7);
        wr(OFF_MASK, bitv(FLAG_INTERVAL));
        wr(OFF_CARRIER, 32'h0000_0101);
        n = 2 + ($random(seed) & 7);
        wr(OFF_INTERVAL, n);
        wr(OFF_CTRL, bitv(CTRL_RUN) | bitv(CTRL_DIR) | bitv(CTRL_FINE));
        wt(2);
        hi = 0;
        for (int i = 0; i < 30; i++) begin
            wt(1);
            if (sendPinOut !== 1'b0) hi++;
        end
        chk(hi, 32'h0, "idle level");
        chk({31'h0, irq}, 32'h1, "interval irq");
        rdr(OFF_COUNT);
        chk_range(rd, 32'h0, n, "down count");
        wr(OFF_CTRL, 32'h0);
        wr(OFF_STATUS, 32'h7);
        wt(2);
        chk({31'h0, irq}, 32'h0, "interval cleared");
        $display("test interval done");

        wr(OFF_MASK, 32'h0);
        wr(OFF_COUNT, 32'h0000_FFF0);
        wt(5);
        rdr(OFF_COUNT);
        chk(rd, 32'h0000_FFF0, "held while off");
        wr(OFF_CTRL, bitv(CTRL_RUN) | bitv(CTRL_FINE));
        wt(40);
        chk({31'h0, irq}, 32'h0, "wrap masked");
        rdr(OFF_STATUS);
        chk(rd, 32'h1, "wrap flag");
        rdr(OFF_COUNT);
        c1 = rd;
        chk_range(rd, 32'h1, 32'h40, "wrapped up count");
        rdr(OFF_COUNT);
        chk_range(rd, c1 + 1, c1 + 20, "counts up");
        wr(OFF_MASK, 32'h1);
        wt(2);
        chk({31'h0, irq}, 32'h1, "wrap irq");
        wr(OFF_STATUS, 32'h0);
        wt(2);
        rdr(OFF_STATUS);
        chk({rd[30:0], irq}, 32'h3, "flag sticky");
        wr(OFF_STATUS, 32'h1);
        wt(2);
        chk({31'h0, irq}, 32'h0, "flag cleared");
        wr(OFF_CTRL, 32'h0);
        $display("test wrap done");

        wr(OFF_STATUS, 32'h7);
        wr(OFF_MASK, bitv(FLAG_CAPTURE));
        wr(OFF_COUNT, 32'h0000_0100);
        wr(OFF_CTRL, bitv(CTRL_RUN) | bitv(CTRL_FINE) | bitv(CTRL_RESTART)
                     | bitv(CTRL_EDGE_LO));
        wt(20);
        @(posedge clk_sys);
        rxWanted <= 1'b1;
        wt(4);
        chk({31'h0, irq}, 32'h1, "capture irq");
        rdr(OFF_CAPTURE);
        chk_range(rd, 32'h100, 32'h140, "capture value");
        rdr(OFF_COUNT);
        chk_range(rd, 32'h1, 32'h20, "restart count");
        wr(OFF_STATUS, 32'h7);
        wr(OFF_CTRL, bitv(CTRL_RUN) | bitv(CTRL_FINE)
                     | bitv(CTRL_EDGE_LO + 1));
        rdr(OFF_COUNT);
        c1 = rd;
        @(posedge clk_sys);
        rxWanted <= 1'b0;
        wt(4);
        rdr(OFF_STATUS);
        chk(rd, bitv(FLAG_CAPTURE), "fall captured");
        @(posedge clk_sys);
        rxWanted <= 1'b1;
        wt(4);
        rdr(OFF_COUNT);
        chk_range(rd, c1 + 1, c1 + 32'h40, "free running");
        $display("test capture done");

        wr(OFF_CTRL, bitv(CTRL_RUN) | bitv(CTRL_DIR) | bitv(CTRL_DATA));
        wt(5);
        @(posedge clk_sys);
        rst <= 1'b1;
        wt(1);
        chk({31'h0, sendPinOe}, 32'h0, "pin in reset");
        @(posedge clk_sys);
        rst <= 1'b0;
        wt(1);
        rdr(OFF_CTRL);
        chk(rd, 32'h0, "ctrl after reset");
        $display("test reset done");
        test_done;
    end
endmodule
`default_nettype wire
